// [swwc_ctrl.sv]
`timescale 1ns/1ps
// Function
// - standby field 001 picks deep stop, 011 light idle; others forbidden.
// - leave low power only on enabled interrupt, nmi or reset.
// - deep stop wakes only on external pins 0 to 5 or reset pin.
// - after interrupt wake, the cpu services that interrupt.
// - watchdog and low-voltage nmi wake light idle only.
// - system tick wakes light idle only.
// - reset-pin wake gives normal mode, all registers at reset values.
// - reset wake from deep stop runs no warm-up; reset held externally.
// - interrupt wake from deep stop runs warm-up, then clock enabled.
// - deep-stop return resets oscillator and pll bits to reset values, keeps warm-up count.
// - only deep stop to normal uses warm-up; others immediate.
// - failed deep-stop entry keeps oscillator, pll and warm-up selects.
// - after reset or deep-stop wake, clock from internal fast oscillator.
module swwc_ctrl
    import swwc_pkg::*;
#(
    parameter int WARMUP_TICK_CYC = SWWC_WARMUP_TICK_CYC
)
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        sleep_req,
    input  wire logic                        stop_abort,
    input  wire logic [SWWC_STBY_W-1:0]      standby_mode_wr,
    input  wire logic                        standby_mode_we,
    input  wire logic [SWWC_WARMUP_W-1:0]    warmup_count_wr,
    input  wire logic                        pll_clock_select_wr,
    input  wire logic                        pll_power_on_wr,
    input  wire logic                        warmup_clock_select_wr,
    input  wire logic                        oscillator_select_wr,
    input  wire logic                        oscillator_enable_a_wr,
    input  wire logic                        oscillator_enable_b_wr,
    input  wire logic                        osc_ctrl_we,
    input  wire logic [SWWC_EXT_PINS-1:0]    external_pin_interrupts,
    input  wire logic [SWWC_PERIPH_SRCS-1:0] periph_interrupts,
    input  wire logic                        tick_interrupt,
    input  wire logic                        watchdog_nmi,
    input  wire logic                        low_voltage_nmi,
    output logic [SWWC_STBY_W-1:0]           standby_mode,
    output logic [SWWC_WARMUP_W-1:0]         warmup_count,
    output logic                             pll_clock_select,
    output logic                             pll_power_on,
    output logic                             warmup_clock_select,
    output logic                             oscillator_select,
    output logic                             oscillator_enable_a,
    output logic                             oscillator_enable_b,
    output logic                             cpu_clock_en,
    output logic                             sys_clock_en,
    output logic                             fast_osc_run,
    output logic                             wake_event,
    output logic                             service_int,
    output logic                             mode_idle,
    output logic                             mode_stop,
    output logic                             warmup_busy
);

    ////////////////////////////////////////////////////////////////////////
    swwc_state_t              state_reg;
    swwc_state_t              state_next;
    logic [SWWC_STBY_W-1:0]   standby_mode_reg;
    logic [SWWC_WARMUP_W-1:0] warmup_count_reg;
    logic [SWWC_WARMUP_W-1:0] warm_cnt_reg;
    logic [SWWC_WARMUP_W-1:0] warm_cnt_next;
    logic [31:0]              tick_cnt_reg;
    logic [31:0]              tick_cnt_next;
    logic                     pll_sel_reg;
    logic                     pll_on_reg;
    logic                     wup_sel_reg;
    logic                     osc_sel_reg;
    logic                     osc_en_a_reg;
    logic                     osc_en_b_reg;
    logic                     wake_event_reg;
    logic                     service_reg;
    logic                     pend_int_reg;

    swwc_wake_if wk ();

    assign wk.ext_pin_req = external_pin_interrupts;
    assign wk.periph_req  = periph_interrupts;
    assign wk.tick_req    = tick_interrupt;
    assign wk.wdt_nmi     = watchdog_nmi;
    assign wk.lvd_nmi     = low_voltage_nmi;
    assign wk.in_idle     = (state_reg == SWWC_ST_IDLE);
    assign wk.in_stop     = (state_reg == SWWC_ST_STOP);

    swwc_wake_filter u_filter (
        .w (wk.filt)
    );

    ////////////////////////////////////////////////////////////////////////
    logic wake_any;
    logic sel_stop;
    logic sel_idle;
    logic enter_stop;
    logic enter_idle;
    logic stop_wake;
    logic tick_done;
    logic warm_done;
    logic sw_write_ok;

    logic sel_clear;
    logic sel_load;
    logic mode_load;
    logic idle_wake;
    logic back_normal;

    assign sel_stop   = (standby_mode_reg == SWWC_STBY_DEEP_STOP);
    assign sel_idle   = (standby_mode_reg == SWWC_STBY_LIGHT_IDLE);
    assign wake_any   = wk.wake_int | wk.wake_nmi;
    assign enter_stop = (state_reg == SWWC_ST_NORMAL) & sleep_req & sel_stop & ~stop_abort;
    assign enter_idle = (state_reg == SWWC_ST_NORMAL) & sleep_req & sel_idle;
    assign stop_wake  = (state_reg == SWWC_ST_STOP) & wk.wake_int;
    // prescaler lets one count unit span several clocks
    assign tick_done  = (tick_cnt_reg == 32'(WARMUP_TICK_CYC - 1));
    assign warm_done  = (warm_cnt_reg == {SWWC_WARMUP_W{1'b0}});
    // registers only writable while the cpu runs
    assign sw_write_ok = (state_reg == SWWC_ST_NORMAL);

    // named strobes keep the flops below short
    assign sel_clear   = stop_wake;
    assign sel_load    = sw_write_ok & osc_ctrl_we;
    assign mode_load   = sw_write_ok & standby_mode_we;
    assign idle_wake   = wk.in_idle & wake_any;
    assign back_normal = (state_reg != SWWC_ST_NORMAL) & (state_next == SWWC_ST_NORMAL);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next    = state_reg;
        warm_cnt_next = warm_cnt_reg;
        tick_cnt_next = tick_cnt_reg;
        case (state_reg)
            SWWC_ST_NORMAL:
            begin
                if (enter_idle)
                    state_next = SWWC_ST_IDLE;
                else if (enter_stop)
                    state_next = SWWC_ST_STOP;
            end
            SWWC_ST_IDLE:
            begin
                if (wake_any)
                    state_next = SWWC_ST_NORMAL;
            end
            SWWC_ST_STOP:
            begin
                if (stop_wake)
                begin
                    state_next    = SWWC_ST_WARMUP;
                    warm_cnt_next = warmup_count_reg;
                    tick_cnt_next = 32'h0000_0000;
                end
            end
            SWWC_ST_WARMUP:
            begin
                if (warm_done)
                    state_next = SWWC_ST_NORMAL;
                else if (tick_done)
                begin
                    tick_cnt_next = 32'h0000_0000;
                    warm_cnt_next = warm_cnt_reg - 12'h001;
                end
                else
                    tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
            end
            default:
                state_next = SWWC_ST_NORMAL;
        endcase
    end

    // reset wake skips warm-up
    // a reset during warm-up drops the count; nothing resumes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= SWWC_ST_NORMAL;
            warm_cnt_reg <= SWWC_WARMUP_RESET;
            tick_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg    <= state_next;
            warm_cnt_reg <= warm_cnt_next;
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            standby_mode_reg <= SWWC_STBY_LIGHT_IDLE;
            warmup_count_reg <= SWWC_WARMUP_RESET;
        end
        else
        begin
            if (mode_load)
                standby_mode_reg <= standby_mode_wr;
            if (sel_load)
                warmup_count_reg <= warmup_count_wr;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pll_sel_reg  <= SWWC_PLL_SEL_RESET;
            pll_on_reg   <= SWWC_PLL_ON_RESET;
            wup_sel_reg  <= SWWC_WUP_CLK_SEL_RESET;
            osc_sel_reg  <= SWWC_OSC_SEL_RESET;
            osc_en_a_reg <= SWWC_OSC_EN_A_RESET;
            osc_en_b_reg <= SWWC_OSC_EN_B_RESET;
        end
        // aborted entry never reaches here
        // clear beats a write, though no write lands outside normal
        else if (sel_clear)
        begin
            pll_sel_reg  <= SWWC_PLL_SEL_RESET;
            pll_on_reg   <= SWWC_PLL_ON_RESET;
            wup_sel_reg  <= SWWC_WUP_CLK_SEL_RESET;
            osc_sel_reg  <= SWWC_OSC_SEL_RESET;
            osc_en_a_reg <= SWWC_OSC_EN_A_RESET;
            osc_en_b_reg <= SWWC_OSC_EN_B_RESET;
        end
        else if (sel_load)
        begin
            pll_sel_reg  <= pll_clock_select_wr;
            pll_on_reg   <= pll_power_on_wr;
            wup_sel_reg  <= warmup_clock_select_wr;
            osc_sel_reg  <= oscillator_select_wr;
            osc_en_a_reg <= oscillator_enable_a_wr;
            osc_en_b_reg <= oscillator_enable_b_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending interrupt held across warm-up so the cpu services it after
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wake_event_reg <= 1'b0;
            pend_int_reg   <= 1'b0;
            service_reg    <= 1'b0;
        end
        else
        begin
            wake_event_reg <= idle_wake | stop_wake;
            if (stop_wake)
                pend_int_reg <= 1'b1;
            else if (state_next == SWWC_ST_NORMAL)
                pend_int_reg <= 1'b0;
            service_reg <= back_normal & (idle_wake | pend_int_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign standby_mode        = standby_mode_reg;
    assign warmup_count        = warmup_count_reg;
    assign pll_clock_select    = pll_sel_reg;
    assign pll_power_on        = pll_on_reg;
    assign warmup_clock_select = wup_sel_reg;
    assign oscillator_select   = osc_sel_reg;
    assign oscillator_enable_a = osc_en_a_reg;
    assign oscillator_enable_b = osc_en_b_reg;
    assign wake_event          = wake_event_reg;
    assign service_int         = service_reg;
    assign mode_idle           = (state_reg == SWWC_ST_IDLE);
    assign mode_stop           = (state_reg == SWWC_ST_STOP);
    assign warmup_busy         = (state_reg == SWWC_ST_WARMUP);
    assign cpu_clock_en        = (state_reg == SWWC_ST_NORMAL);
    // system clock gated in stop and warm-up
    assign sys_clock_en        = (state_reg == SWWC_ST_NORMAL) | (state_reg == SWWC_ST_IDLE);
    // oscillator runs except in stop
    // warm-up needs it running before the clock opens
    assign fast_osc_run        = (state_reg != SWWC_ST_STOP);

endmodule

// [swwc_ctrl_monitor.sv]
`timescale 1ns/1ps
module swwc_ctrl_monitor
    import swwc_pkg::*;
#(
    parameter int WARMUP_TICK_CYC = 1
)
(
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        sleep_req,
    input wire logic                        stop_abort,
    input wire logic                        osc_ctrl_we,
    input wire logic [SWWC_STBY_W-1:0]      standby_mode,
    input wire logic [SWWC_WARMUP_W-1:0]    warmup_count,
    input wire logic                        pll_clock_select,
    input wire logic                        pll_power_on,
    input wire logic                        oscillator_select,
    input wire logic                        oscillator_enable_a,
    input wire logic [SWWC_EXT_PINS-1:0]    external_pin_interrupts,
    input wire logic [SWWC_PERIPH_SRCS-1:0] periph_interrupts,
    input wire logic                        tick_interrupt,
    input wire logic                        watchdog_nmi,
    input wire logic                        low_voltage_nmi,
    input wire logic                        cpu_clock_en,
    input wire logic                        sys_clock_en,
    input wire logic                        fast_osc_run,
    input wire logic                        wake_event,
    input wire logic                        service_int,
    input wire logic                        mode_idle,
    input wire logic                        mode_stop,
    input wire logic                        warmup_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] wu_cnt;
    wire         pin_req = |external_pin_interrupts;
    wire         any_req = pin_req || |periph_interrupts || tick_interrupt
                           || watchdog_nmi || low_voltage_nmi;
    wire         go_deep = cpu_clock_en && sleep_req && standby_mode == SWWC_STBY_DEEP_STOP;
    ////////////////////////////////////////////////////////////////
    // counts warm-up cycles so the length check needs no long repetition
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wu_cnt <= '0;
        else
            wu_cnt <= warmup_busy ? wu_cnt + 16'h0001 : 16'h0000;
    end
    sequence s_back_normal;
        (cpu_clock_en && wake_event && service_int) ##1 (!wake_event && !service_int);
    endsequence
    sequence s_stop_wake;
        warmup_busy && wake_event && !pll_power_on && !pll_clock_select && oscillator_enable_a;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_STOP_HOLD:
        assert property (mode_stop && !pin_req |=> mode_stop && !wake_event)
        else $error("deep stop left without a pin request");
    AST_STOP_WAKE:
        assert property (mode_stop && pin_req |=> s_stop_wake ##0 $stable(warmup_count))
        else $error("pin wake from deep stop wrong");
    AST_IDLE_WAKE:
        assert property (mode_idle && any_req |=> s_back_normal)
        else $error("idle wake sequence wrong");
    AST_IDLE_HOLD:
        assert property (mode_idle && !any_req |=> mode_idle)
        else $error("idle left without a request");
    AST_SLEEP_IDLE:
        assert property (cpu_clock_en && sleep_req && standby_mode == SWWC_STBY_LIGHT_IDLE
                         |=> mode_idle && sys_clock_en && !cpu_clock_en)
        else $error("idle entry wrong");
    AST_SLEEP_STOP:
        assert property (go_deep && !stop_abort |=> mode_stop && !fast_osc_run && !sys_clock_en)
        else $error("deep stop entry wrong");
    AST_ABORT_KEEP:
        assert property (go_deep && stop_abort && !osc_ctrl_we
                         |=> cpu_clock_en && $stable(oscillator_select) && $stable(pll_power_on))
        else $error("aborted entry changed state");
    AST_WARMUP_LEN:
        assert property ($fell(warmup_busy) |-> wu_cnt == warmup_count * WARMUP_TICK_CYC + 1)
        else $error("warm-up length wrong");
    AST_WARMUP_CLK:
        assert property (warmup_busy |-> !sys_clock_en && fast_osc_run && !cpu_clock_en)
        else $error("clock enabled during warm-up");
    AST_SERVICE:
        assert property ($fell(warmup_busy) |-> (cpu_clock_en && service_int) ##1 !service_int)
        else $error("no service after warm-up");
endmodule

// [swwc_pkg.sv]
package swwc_pkg;

    // standby-mode field encodings
    localparam logic [2:0] SWWC_STBY_DEEP_STOP  = 3'h1;
    localparam logic [2:0] SWWC_STBY_LIGHT_IDLE = 3'h3;
    localparam int         SWWC_STBY_W          = 3;

    // warm-up count field
    localparam int          SWWC_WARMUP_W     = 12;
    localparam logic [11:0] SWWC_WARMUP_RESET = 12'h000;
    localparam logic [11:0] SWWC_WARMUP_FLASH = 12'h119;

    // oscillator / pll selection bits after reset or deep-stop wake
    localparam logic SWWC_PLL_SEL_RESET     = 1'b0;
    localparam logic SWWC_PLL_ON_RESET      = 1'b0;
    localparam logic SWWC_WUP_CLK_SEL_RESET = 1'b0;
    localparam logic SWWC_OSC_SEL_RESET     = 1'b0;
    localparam logic SWWC_OSC_EN_A_RESET    = 1'b1;
    localparam logic SWWC_OSC_EN_B_RESET    = 1'b0;

    // wake source counts
    localparam int SWWC_EXT_PINS     = 6;
    localparam int SWWC_PERIPH_SRCS  = 32;

    // clock rate and warm-up tick derivation
    localparam int SWWC_CLK_MHZ          = 200;
    localparam int SWWC_WARMUP_TICK_NS   = 5;
    localparam int SWWC_WARMUP_TICK_CYC  = (SWWC_WARMUP_TICK_NS * SWWC_CLK_MHZ) / 1000 < 1 ? 1
                                         : (SWWC_WARMUP_TICK_NS * SWWC_CLK_MHZ) / 1000;

    typedef enum logic [3:0] {
        SWWC_ST_NORMAL = 4'h1,
        SWWC_ST_IDLE   = 4'h2,
        SWWC_ST_STOP   = 4'h4,
        SWWC_ST_WARMUP = 4'h8
    } swwc_state_t;

endpackage

// [swwc_wake_filter.sv]
`timescale 1ns/1ps
module swwc_wake_filter
    import swwc_pkg::*;
(
    swwc_wake_if.filt w
);
    logic stop_ok;
    logic idle_ok;

    assign stop_ok = w.in_stop & (|w.ext_pin_req);
    assign idle_ok = w.in_idle & ((|w.ext_pin_req) | (|w.periph_req) | w.tick_req);

    assign w.wake_int = stop_ok | idle_ok;
    assign w.wake_nmi = w.in_idle & (w.wdt_nmi | w.lvd_nmi);
endmodule

// [swwc_wake_if.sv]
`timescale 1ns/1ps
interface swwc_wake_if;
    import swwc_pkg::*;
    logic [SWWC_EXT_PINS-1:0]    ext_pin_req;
    logic [SWWC_PERIPH_SRCS-1:0] periph_req;
    logic                        tick_req;
    logic                        wdt_nmi;
    logic                        lvd_nmi;
    logic                        in_idle;
    logic                        in_stop;
    logic                        wake_int;
    logic                        wake_nmi;

    modport ctrl (
        output ext_pin_req,
        output periph_req,
        output tick_req,
        output wdt_nmi,
        output lvd_nmi,
        output in_idle,
        output in_stop,
        input  wake_int,
        input  wake_nmi
    );
    modport filt (
        input  ext_pin_req,
        input  periph_req,
        input  tick_req,
        input  wdt_nmi,
        input  lvd_nmi,
        input  in_idle,
        input  in_stop,
        output wake_int,
        output wake_nmi
    );
endinterface

// [swwc_wake_partner.sv]
`timescale 1ns/1ps
module swwc_wake_partner
    import swwc_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    fire,
    input  wire logic                    drop,
    input  wire logic [2:0]              kind,
    input  wire logic [4:0]              pbit,
    input  wire logic                    service_int,
    output logic [SWWC_EXT_PINS-1:0]    external_pin_interrupts,
    output logic [SWWC_PERIPH_SRCS-1:0] periph_interrupts,
    output logic                        tick_interrupt,
    output logic                        watchdog_nmi,
    output logic                        low_voltage_nmi
);
    // one-hot {lvd, wdt, tick, periph, pin}
    logic [4:0] req;
    // level held until serviced or dropped, one source only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            req <= '0;
        else if (fire)
            req <= 5'h01 << kind;
        else if (drop || service_int)
            req <= '0;
    end
    // pins arrive enabled; nmi only when commanded
    assign external_pin_interrupts = req[0] ? 6'h01 << (pbit % 5'h06) : '0;
    assign periph_interrupts       = req[1] ? 32'h00000001 << pbit : '0;
    assign tick_interrupt          = req[2];
    assign watchdog_nmi            = req[3];
    assign low_voltage_nmi         = req[4];
endmodule

// [test_standby_wakeup_warmup_ctrl.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_standby_wakeup_warmup_ctrl;
    import swwc_pkg::*;
    localparam int         TICK    = 1;
    localparam logic [5:0] SEL_RST = {SWWC_PLL_SEL_RESET, SWWC_PLL_ON_RESET,
        SWWC_WUP_CLK_SEL_RESET, SWWC_OSC_SEL_RESET, SWWC_OSC_EN_A_RESET, SWWC_OSC_EN_B_RESET};
    logic        clk, rst, sleep_req, stop_abort, standby_mode_we, osc_ctrl_we, fire, drop;
    logic        tick_interrupt, watchdog_nmi, low_voltage_nmi, cpu_clock_en, sys_clock_en;
    logic        fast_osc_run, wake_event, service_int, mode_idle, mode_stop, warmup_busy;
    logic [2:0]  standby_mode_wr, standby_mode, kind;
    logic [4:0]  pbit;
    logic [5:0]  sel_wr, m_sel;
    wire  [5:0]  sel;
    logic [11:0] warmup_count_wr, warmup_count, m_wc;
    logic [SWWC_EXT_PINS-1:0]    external_pin_interrupts;
    logic [SWWC_PERIPH_SRCS-1:0] periph_interrupts;
    int          n_errors, samples_checked, n, k;
    swwc_ctrl #(.WARMUP_TICK_CYC(TICK)) i_dut (.clk(clk), .rst(rst), .sleep_req(sleep_req),
        .stop_abort(stop_abort), .standby_mode_wr(standby_mode_wr),
        .standby_mode_we(standby_mode_we), .warmup_count_wr(warmup_count_wr),
        .pll_clock_select_wr(sel_wr[5]), .pll_power_on_wr(sel_wr[4]),
        .warmup_clock_select_wr(sel_wr[3]), .oscillator_select_wr(sel_wr[2]),
        .oscillator_enable_a_wr(sel_wr[1]), .oscillator_enable_b_wr(sel_wr[0]),
        .osc_ctrl_we(osc_ctrl_we), .external_pin_interrupts(external_pin_interrupts),
        .periph_interrupts(periph_interrupts), .tick_interrupt(tick_interrupt),
        .watchdog_nmi(watchdog_nmi), .low_voltage_nmi(low_voltage_nmi),
        .standby_mode(standby_mode), .warmup_count(warmup_count), .pll_clock_select(sel[5]),
        .pll_power_on(sel[4]), .warmup_clock_select(sel[3]), .oscillator_select(sel[2]),
        .oscillator_enable_a(sel[1]), .oscillator_enable_b(sel[0]),
        .cpu_clock_en(cpu_clock_en), .sys_clock_en(sys_clock_en), .fast_osc_run(fast_osc_run),
        .wake_event(wake_event), .service_int(service_int), .mode_idle(mode_idle),
        .mode_stop(mode_stop), .warmup_busy(warmup_busy));
    swwc_wake_partner i_far (.clk(clk), .rst(rst), .fire(fire), .drop(drop), .kind(kind),
        .pbit(pbit), .service_int(service_int), .external_pin_interrupts(external_pin_interrupts),
        .periph_interrupts(periph_interrupts), .tick_interrupt(tick_interrupt),
        .watchdog_nmi(watchdog_nmi), .low_voltage_nmi(low_voltage_nmi));
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic hit(input int w);
        case (w)
            0: return cpu_clock_en === 1'b1;
            1: return mode_idle === 1'b1;
            2: return mode_stop === 1'b1;
            default: return service_int === 1'b1;
        endcase
    endfunction
    // bounded wait; running out ends the run
    task automatic wait_until(input int w, input int lim);
        for (int j = 0; j < lim && !hit(w); j++)
            @(negedge clk);
        `CHK(hit(w), 1'b1)
        if (!hit(w))
            end_of_test();
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic sleep(input logic ab);
        stop_abort = ab;
        pulse(sleep_req);
        stop_abort = 1'b0;
    endtask
    task automatic set_mode(input logic [2:0] m);
        standby_mode_wr = m;
        pulse(standby_mode_we);
        `CHK(standby_mode, m)
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        {rst, sleep_req, stop_abort, standby_mode_we, osc_ctrl_we, fire, drop} = 7'h40;
        {standby_mode_wr, kind, pbit, sel_wr, warmup_count_wr} = '0;
        n_errors = 0;
        samples_checked = 0;
        void'($urandom(5511));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        `CHK(standby_mode, SWWC_STBY_LIGHT_IDLE)
        `CHK(warmup_count, SWWC_WARMUP_RESET)
        `CHK({sel, cpu_clock_en, fast_osc_run}, {SEL_RST, 2'h3})
        $display("test reset_values done");
        // every wake class from light idle, back to back
        for (k = 0; k < 5; k++)
        begin
            sleep(1'b0);
            wait_until(1, 10);
            `CHK(sys_clock_en, 1'b1)
            pbit = 5'($urandom_range(31));
            kind = 3'(k);
            pulse(fire);
            wait_until(3, 10);
            `CHK({wake_event, cpu_clock_en}, 2'h3)
        end
        $display("test idle_wake done");
        // software side: count 0x119, warm-up clock equal to oscillator select
        m_sel = 6'($urandom_range(63));
        m_sel = {2'h3, m_sel[2], m_sel[2:0]};
        m_wc = SWWC_WARMUP_FLASH;
        sel_wr = m_sel;
        warmup_count_wr = m_wc;
        pulse(osc_ctrl_we);
        set_mode(SWWC_STBY_DEEP_STOP);
        sleep(1'b1);
        `CHK({cpu_clock_en, sel, warmup_count}, {1'b1, m_sel, m_wc})
        $display("test aborted_entry done");
        sleep(1'b0);
        wait_until(2, 10);
        `CHK({fast_osc_run, sys_clock_en}, 2'h0)
        // deliberately raise idle-only sources in deep stop
        for (k = 1; k < 5; k++)
        begin
            kind = 3'(k);
            pulse(fire);
            repeat (3) @(negedge clk);
            `CHK({mode_stop, wake_event}, 2'h2)
            pulse(drop);
        end
        kind = 3'h0;
        pulse(fire);
        n = 0;
        for (int j = 0; j < 2000 && (n == 0 || warmup_busy === 1'b1); j++)
        begin
            n += (warmup_busy === 1'b1);
            @(negedge clk);
        end
        `CHK(n, int'(m_wc) * TICK + 1)
        `CHK({sel, warmup_count}, {SEL_RST, m_wc})
        wait_until(3, 4);
        $display("test deep_stop_wake done");
        set_mode(SWWC_STBY_DEEP_STOP);
        sleep(1'b0);
        wait_until(2, 10);
        pulse(rst);
        @(negedge clk);
        `CHK({cpu_clock_en, warmup_busy, mode_stop}, 3'h4)
        `CHK({standby_mode, warmup_count}, {SWWC_STBY_LIGHT_IDLE, SWWC_WARMUP_RESET})
        $display("test reset_wake done");
        end_of_test();
    end
endmodule
bind swwc_ctrl swwc_ctrl_monitor #(.WARMUP_TICK_CYC(WARMUP_TICK_CYC)) i_mon (.clk(clk),
    .rst(rst), .sleep_req(sleep_req), .stop_abort(stop_abort), .osc_ctrl_we(osc_ctrl_we),
    .standby_mode(standby_mode), .warmup_count(warmup_count),
    .pll_clock_select(pll_clock_select), .pll_power_on(pll_power_on),
    .oscillator_select(oscillator_select), .oscillator_enable_a(oscillator_enable_a),
    .external_pin_interrupts(external_pin_interrupts), .periph_interrupts(periph_interrupts),
    .tick_interrupt(tick_interrupt), .watchdog_nmi(watchdog_nmi),
    .low_voltage_nmi(low_voltage_nmi), .cpu_clock_en(cpu_clock_en),
    .sys_clock_en(sys_clock_en), .fast_osc_run(fast_osc_run), .wake_event(wake_event),
    .service_int(service_int), .mode_idle(mode_idle), .mode_stop(mode_stop),
    .warmup_busy(warmup_busy));
